// ### bbes_defines.svh
// Constants for the buck-boost enable sequencer: offsets, fields, resets, timing.
`ifndef BBES_DEFINES_SVH
`define BBES_DEFINES_SVH

// Clock rate and derived cycle counts.
`define BBES_CLK_HZ          20000000
`define BBES_SS_TIME_US      3900
`define BBES_SS_CYCLES       ((`BBES_SS_TIME_US) * (`BBES_CLK_HZ / 1000000))
`define BBES_STRAP_TIME_US   1
`define BBES_STRAP_CYCLES    ((`BBES_STRAP_TIME_US) * (`BBES_CLK_HZ / 1000000))

// Register offsets.
`define BBES_ADDR_REF_LO     8'h00
`define BBES_ADDR_REF_HI     8'h01
`define BBES_ADDR_FB         8'h04
`define BBES_ADDR_CTRL       8'h06
`define BBES_ADDR_STATUS     8'h07

// Field positions in the control register.
`define BBES_CTRL_OE         7
`define BBES_CTRL_BLEED      6
`define BBES_CTRL_DITHER     4
`define BBES_CTRL_RATE_HI    3
`define BBES_CTRL_RATE_LO    2
`define BBES_CTRL_FIXED      1
// Field positions in the feedback register.
`define BBES_FB_SEL          7
`define BBES_FB_RATIO_HI     1
`define BBES_FB_RATIO_LO     0

// Reset values.
`define BBES_REF_RST         11'h11A
`define BBES_CTRL_RST        8'h00
`define BBES_FB_RST          8'h00

// Strap target addresses.
`define BBES_ADDR_STRAP_HI   7'h75
`define BBES_ADDR_STRAP_LO   7'h74

// Switching rates, dither span and triangle rates.
`define BBES_RATE0_KHZ       400
`define BBES_RATE1_KHZ       800
`define BBES_RATE2_KHZ       1600
`define BBES_RATE3_KHZ       2100
`define BBES_DITHER_PCT      7
`define BBES_MOD0_HZ         1500
`define BBES_MOD1_HZ         3000
`define BBES_MOD2_HZ         6000
`define BBES_MOD3_HZ         9000
`define BBES_DEV(k)          ((k) * `BBES_DITHER_PCT / 100)
`define BBES_STEP(m, k)      (`BBES_CLK_HZ / ((m) * 4 * `BBES_DEV(k)))

`endif

// ### bbes_pkg.sv
// Types shared by the buck-boost enable sequencer.
package bbes_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    BBES_OFF,
    BBES_STANDBY,
    BBES_READY,
    BBES_SOFTSTART,
    BBES_RUN
  } bbes_state_t;

endpackage : bbes_pkg

// ### bbes_rate_gen.sv
// Switching rate selection with triangle frequency dither.
`timescale 1ns/100ps
`include "bbes_defines.svh"
module bbes_rate_gen #(
  parameter int FREQ_W = 12,
  parameter int STEP_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [1:0]        rate_sel_i,
  input  wire logic              dither_en_i,
  output logic      [FREQ_W-1:0] freq_khz_o
);

  logic        [FREQ_W-1:0] nom;     // Nominal rate in kHz.
  logic signed [FREQ_W-1:0] dev;     // Largest dither offset in kHz.
  logic        [STEP_W-1:0] step;    // Cycles between offset steps.
  logic signed [FREQ_W-1:0] offset;  // Present dither offset.
  logic        [STEP_W-1:0] cnt;     // Step interval counter.
  logic                     up;      // Triangle direction.

  ////////////////////////////////////////////////////////////////////////////
  // Nominal rate, span and triangle pace for each setting.
  always_comb begin
    case (rate_sel_i)
      2'd0: begin
        nom  = FREQ_W'(`BBES_RATE0_KHZ);
        dev  = FREQ_W'(`BBES_DEV(`BBES_RATE0_KHZ));
        step = STEP_W'(`BBES_STEP(`BBES_MOD0_HZ, `BBES_RATE0_KHZ));
      end
      2'd1: begin
        nom  = FREQ_W'(`BBES_RATE1_KHZ);
        dev  = FREQ_W'(`BBES_DEV(`BBES_RATE1_KHZ));
        step = STEP_W'(`BBES_STEP(`BBES_MOD1_HZ, `BBES_RATE1_KHZ));
      end
      2'd2: begin
        nom  = FREQ_W'(`BBES_RATE2_KHZ);
        dev  = FREQ_W'(`BBES_DEV(`BBES_RATE2_KHZ));
        step = STEP_W'(`BBES_STEP(`BBES_MOD2_HZ, `BBES_RATE2_KHZ));
      end
      default: begin
        nom  = FREQ_W'(`BBES_RATE3_KHZ);
        dev  = FREQ_W'(`BBES_DEV(`BBES_RATE3_KHZ));
        step = STEP_W'(`BBES_STEP(`BBES_MOD3_HZ, `BBES_RATE3_KHZ));
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Triangle walk of one kHz per step between minus and plus span.
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !dither_en_i) begin
      offset <= '0;
      cnt    <= '0;
      up     <= 1'b1;
    end else if (cnt >= step - STEP_W'(1)) begin
      cnt <= '0;
      // Turn at either end so the span never exceeds the limit.
      if (up && offset >= dev) begin
        up     <= 1'b0;
        offset <= offset - FREQ_W'(1);
      end else if (!up && offset <= -dev) begin
        up     <= 1'b1;
        offset <= offset + FREQ_W'(1);
      end else begin
        offset <= up ? offset + FREQ_W'(1) : offset - FREQ_W'(1);
      end
    end else begin
      cnt <= cnt + STEP_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered rate word for the power stage.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      freq_khz_o <= FREQ_W'(`BBES_RATE0_KHZ);
    end else begin
      freq_khz_o <= nom + offset;
    end
  end

  a_dither_span : assert property (@(posedge clk_i) disable iff (!resetn_i)
    (offset <= dev + FREQ_W'(1)) && (offset >= -dev - FREQ_W'(1)))
    else $error("dither offset outside span");

endmodule : bbes_rate_gen

// ### bbes_sequencer.sv
// Enable, strap, soft-start, discharge and rate control of the converter.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "bbes_defines.svh"
module bbes_sequencer
  import bbes_pkg::*;
#(
  parameter int SS_CYCLES = `BBES_SS_CYCLES,
  parameter int FREQ_W    = 12
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Register port.
  input  wire logic [7:0]        addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rd_data_o,
  // Analog comparator levels, asynchronous.
  input  wire logic              vin_above_3v_i,
  input  wire logic              vin_below_2v4_i,
  input  wire logic              en_logic_high_i,
  input  wire logic              en_above_uvlo_i,
  input  wire logic              en_below_0v4_i,
  input  wire logic              vin_gt_vout_i,
  input  wire logic              lower_above_6v2_i,
  input  wire logic              lower_below_5v9_i,
  input  wire logic              strap_dt1_i,
  input  wire logic              strap_dt2_i,
  input  wire logic              strap_dt3_i,
  input  wire logic              vout_below_0v8_i,
  input  wire logic              vcc_below_uvlo_i,
  // Power stage controls.
  output logic                   ldo_from_vout_o,
  output logic                   bus_active_o,
  output logic      [6:0]        target_addr_o,
  output logic                   switch_en_o,
  output logic      [10:0]       ref_mv_o,
  output logic                   feedback_source_select_o,
  output logic      [1:0]        fb_ratio_o,
  output logic                   forced_fixed_rate_mode_o,
  output logic                   bleed_o,
  output logic                   uvlo_discharge_o,
  output logic      [FREQ_W-1:0] freq_khz_o
);

  localparam int NS = 13; // Number of synchronised comparator levels.

  logic [NS-1:0] meta;      // First synchroniser stage.
  logic [NS-1:0] sync;      // Second stage, safe to use.
  logic          vin_ok_s, vin_low_s, en_high_s, enable_threshold_pin_s, en_off_s;
  logic          vin_gt_s, low_hi_s, low_lo_s, vout_low_s, vcc_low_s;
  logic [2:0]    strap_s;   // Strap comparators, highest first.

  bbes_state_t   state;     // Present sequencer state.
  bbes_state_t   next_state;
  logic [10:0]   setpoint;  // Reference setpoint in millivolts.
  logic [7:0]    fb_reg;    // Feedback register.
  logic [7:0]    ctrl;      // Control register.
  logic          strap_valid;
  logic          default_oe;
  logic [7:0]    strap_cnt; // Strap settling counter.
  logic          lower_hi;  // Lower rail hysteresis flag.
  logic [31:0]   ramp_acc;  // Ramp fraction accumulator.
  logic [10:0]   ramp;      // Ramped reference.
  logic          ramp_done;
  logic          bus_ok;    // Bus and switching permitted.
  logic          oe;
  logic          strap_take;
  logic [7:0]    rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser for every comparator level.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= {vin_above_3v_i, vin_below_2v4_i, en_logic_high_i,
               en_above_uvlo_i, en_below_0v4_i, vin_gt_vout_i,
               lower_above_6v2_i, lower_below_5v9_i, strap_dt1_i,
               strap_dt2_i, strap_dt3_i, vout_below_0v8_i,
               vcc_below_uvlo_i};
      sync <= meta;
    end
  end

  assign {vin_ok_s, vin_low_s, en_high_s, enable_threshold_pin_s, en_off_s, vin_gt_s,
          low_hi_s, low_lo_s, strap_s, vout_low_s, vcc_low_s} = sync;

  assign oe         = ctrl[`BBES_CTRL_OE];
  assign bus_ok     = (state == BBES_READY) || (state == BBES_SOFTSTART) ||
                      (state == BBES_RUN);
  assign strap_take = (state == BBES_STANDBY) && !strap_valid &&
                      (strap_cnt >= 8'(`BBES_STRAP_CYCLES));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state; lockout and pin low win over all else.
  always_comb begin
    next_state = state;
    if (vin_low_s || !en_high_s) begin
      next_state = BBES_OFF;
    end else begin
      case (state)
        BBES_OFF: begin
          if (vin_ok_s) begin
            next_state = BBES_STANDBY;
          end
        end
        BBES_STANDBY: begin
          if (strap_valid && enable_threshold_pin_s) begin
            next_state = BBES_READY;
          end
        end
        BBES_READY: begin
          if (!enable_threshold_pin_s) begin
            next_state = BBES_STANDBY;
          end else if (oe) begin
            next_state = BBES_SOFTSTART;
          end
        end
        BBES_SOFTSTART: begin
          if (!enable_threshold_pin_s) begin
            next_state = BBES_STANDBY;
          end else if (!oe) begin
            next_state = BBES_READY;
          end else if (ramp_done) begin
            next_state = BBES_RUN;
          end
        end
        BBES_RUN: begin
          if (!enable_threshold_pin_s) begin
            next_state = BBES_STANDBY;
          end else if (!oe) begin
            next_state = BBES_READY;
          end
        end
        default: begin
          next_state = BBES_OFF;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= BBES_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap sensing in standby, held until the pin reaches shutdown level.
  always_ff @(posedge clk_i) begin
    if (!resetn_i || en_off_s) begin
      strap_cnt     <= '0;
      strap_valid   <= 1'b0;
      default_oe    <= 1'b0;
      target_addr_o <= `BBES_ADDR_STRAP_HI;
    end else if (state != BBES_STANDBY) begin
      strap_cnt <= '0;
    end else if (strap_take) begin
      strap_valid   <= 1'b1;
      // Highest comparator tripped names the strap resistor.
      casez (strap_s)
        3'b1??: begin
          target_addr_o <= `BBES_ADDR_STRAP_LO;
          default_oe    <= 1'b1;
        end
        3'b01?: begin
          target_addr_o <= `BBES_ADDR_STRAP_LO;
          default_oe    <= 1'b0;
        end
        3'b001: begin
          target_addr_o <= `BBES_ADDR_STRAP_HI;
          default_oe    <= 1'b1;
        end
        default: begin
          target_addr_o <= `BBES_ADDR_STRAP_HI;
          default_oe    <= 1'b0;
        end
      endcase
    end else if (!strap_valid) begin
      strap_cnt <= strap_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, refused until thresholds pass; shutdown resets all.
  always_ff @(posedge clk_i) begin
    if (!resetn_i || en_off_s) begin
      setpoint <= `BBES_REF_RST;
      fb_reg   <= `BBES_FB_RST;
      ctrl     <= `BBES_CTRL_RST;
    end else begin
      if (wr_i && bus_ok) begin
        case (addr_i)
          `BBES_ADDR_REF_LO: setpoint[7:0]  <= wr_data_i;
          `BBES_ADDR_REF_HI: setpoint[10:8] <= wr_data_i[2:0];
          `BBES_ADDR_FB:     fb_reg         <= wr_data_i;
          `BBES_ADDR_CTRL:   ctrl           <= wr_data_i;
          default: begin
          end
        endcase
      end
      // Strap default enable also forces the external divider.
      if (strap_take && strap_s[2] | (strap_s == 3'b001)) begin
        ctrl[`BBES_CTRL_OE] <= 1'b1;
        fb_reg[`BBES_FB_SEL] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start ramp: fraction accumulator gives equal steps per tick.
  always_ff @(posedge clk_i) begin
    if (!resetn_i || (state != BBES_SOFTSTART && state != BBES_RUN)) begin
      ramp     <= '0;
      ramp_acc <= '0;
    end else if (state == BBES_RUN) begin
      ramp <= setpoint;
    end else if (!ramp_done) begin
      if (ramp_acc + {21'h0, setpoint} >= 32'(SS_CYCLES)) begin
        ramp     <= ramp + 11'h001;
        ramp_acc <= ramp_acc + {21'h0, setpoint} - 32'(SS_CYCLES);
      end else begin
        ramp_acc <= ramp_acc + {21'h0, setpoint};
      end
    end
  end

  assign ramp_done = (ramp >= setpoint);

  ////////////////////////////////////////////////////////////////////////////
  // LDO rail choice: lower rail above threshold feeds itself.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lower_hi        <= 1'b0;
      ldo_from_vout_o <= 1'b0;
    end else begin
      if (low_hi_s) begin
        lower_hi <= 1'b1;
      end else if (low_lo_s) begin
        lower_hi <= 1'b0;
      end
      ldo_from_vout_o <= vin_gt_s ? lower_hi : !lower_hi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered controls toward the power stage.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bus_active_o             <= 1'b0;
      switch_en_o              <= 1'b0;
      ref_mv_o                 <= '0;
      feedback_source_select_o <= 1'b0;
      fb_ratio_o               <= '0;
      forced_fixed_rate_mode_o <= 1'b0;
      bleed_o                  <= 1'b0;
      uvlo_discharge_o         <= 1'b0;
    end else begin
      bus_active_o <= bus_ok;
      switch_en_o  <= (state == BBES_SOFTSTART) || (state == BBES_RUN);
      ref_mv_o     <= ramp;
      feedback_source_select_o <= fb_reg[`BBES_FB_SEL];
      fb_ratio_o   <= fb_reg[`BBES_FB_RATIO_HI:`BBES_FB_RATIO_LO];
      forced_fixed_rate_mode_o <= ctrl[`BBES_CTRL_FIXED];
      bleed_o      <= bus_ok && !oe && ctrl[`BBES_CTRL_BLEED] &&
                      !vout_low_s;
      uvlo_discharge_o <= (vin_low_s || !en_high_s) && !vcc_low_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the strobe.
  always_comb begin
    case (addr_i)
      `BBES_ADDR_REF_LO: rd_mux = setpoint[7:0];
      `BBES_ADDR_REF_HI: rd_mux = {5'h00, setpoint[10:8]};
      `BBES_ADDR_FB:     rd_mux = fb_reg;
      `BBES_ADDR_CTRL:   rd_mux = ctrl;
      `BBES_ADDR_STATUS: rd_mux = {2'h0, lower_hi, ramp_done, default_oe,
                                   strap_valid, bus_ok, switch_en_o};
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate generator, dithered only in fixed-rate mode while switching.
  bbes_rate_gen #(
    .FREQ_W (FREQ_W),
    .STEP_W (8)
  ) u_rate (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .rate_sel_i  (ctrl[`BBES_CTRL_RATE_HI:`BBES_CTRL_RATE_LO]),
    .dither_en_i (ctrl[`BBES_CTRL_DITHER] && ctrl[`BBES_CTRL_FIXED] &&
                  switch_en_o),
    .freq_khz_o  (freq_khz_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencing.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_oe_off;
    !oe ##1 !oe;
  endsequence

  sequence s_low_vin_hi;
    (low_hi_s && !vin_gt_s) ##1 !vin_gt_s;
  endsequence

  // The state leaves soft-start one edge after the clear, and the switch
  // output follows the state one edge later still.
  a_oe_off_stop : assert property (s_oe_off |=> ##1 !switch_en_o)
    else $error("switching while output enable is clear");
  a_uvlo_stop : assert property (vin_low_s |=> ##1 !switch_en_o)
    else $error("switching under input lockout");
  a_shutdown_reset : assert property (en_off_s |=> ctrl == `BBES_CTRL_RST
    && setpoint == `BBES_REF_RST)
    else $error("registers not reset in shutdown");
  a_strap_hold : assert property (strap_valid && $past(strap_valid)
    |-> $stable(target_addr_o))
    else $error("strap result changed");
  a_default_oe_fb : assert property ($rose(strap_valid) && default_oe
    |-> oe && fb_reg[`BBES_FB_SEL])
    else $error("default enable did not force feedback select");
  a_write_gate : assert property (wr_i && !bus_ok && !en_off_s
    && !strap_take |=> $stable(ctrl))
    else $error("write taken before thresholds");
  a_ramp_zero : assert property (state == BBES_READY |=> ramp == 11'h000)
    else $error("ramp not restarted from zero");
  a_ramp_bound : assert property (state == BBES_SOFTSTART
    && $past(state) == BBES_SOFTSTART |-> ramp <= setpoint + 11'h001)
    else $error("ramp overshoots setpoint");
  a_ldo_lower : assert property (s_low_vin_hi |=> !ldo_from_vout_o)
    else $error("ldo rail choice wrong");
  a_bleed_cause : assert property (bleed_o |-> $past(!oe
    && ctrl[`BBES_CTRL_BLEED]))
    else $error("bleed without cause");

endmodule : bbes_sequencer

// ### bbes_ctrl_model.sv
// Register-bus controller model that configures the converter.
`timescale 1ns/100ps
module bbes_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wr_data_o,
  output logic            wr_o,
  output logic            rd_o
);
  // The bus idles with both strobes low from time zero.
  initial begin
    addr_o    = 8'h00;
    wr_data_o = 8'h00;
    wr_o      = 1'b0;
    rd_o      = 1'b0;
  end

  // One-cycle write strobe beside address and data.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o    <= a;
    wr_data_o <= d;
    wr_o      <= 1'b1;
    @(posedge clk_i);
    wr_o      <= 1'b0;
    wr_data_o <= ~d;  // Released data must not keep showing the value.
  endtask : write_reg

  // One-cycle read strobe; the data stands only in the following cycle.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rd_data_i;
  endtask : read_reg
endmodule : bbes_ctrl_model

// ### tb.sv
// Self-checking testbench for the buck-boost enable sequencer.
`timescale 1ns/100ps
module tb;
  import bbes_pkg::*;
  localparam int SS = 300;  // Shortened soft-start count.
  localparam logic [11:0] RATES [4] = '{12'h190, 12'h320, 12'h640, 12'h834};
  logic        clk, resetn, wr, rd, ldo, bus, sw, fbsel, fixed, bleed, udis;
  logic        vin3, vin24, en_hi, en_uv, en_off, vgt, l62, l59;
  logic        dt1, dt2, dt3, vo08, vcc_uv;
  logic [7:0]  addr, wdata, rdata;
  logic [6:0]  taddr;
  logic [10:0] ref_mv;
  logic [1:0]  ratio;
  logic [11:0] freq;
  int          fail_count, compares;

  bbes_sequencer #(.SS_CYCLES(SS)) u_bbes_sequencer (.clk_i(clk),
    .resetn_i(resetn), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdata), .vin_above_3v_i(vin3),
    .vin_below_2v4_i(vin24), .en_logic_high_i(en_hi),
    .en_above_uvlo_i(en_uv), .en_below_0v4_i(en_off), .vin_gt_vout_i(vgt),
    .lower_above_6v2_i(l62), .lower_below_5v9_i(l59), .strap_dt1_i(dt1),
    .strap_dt2_i(dt2), .strap_dt3_i(dt3), .vout_below_0v8_i(vo08),
    .vcc_below_uvlo_i(vcc_uv), .ldo_from_vout_o(ldo), .bus_active_o(bus),
    .target_addr_o(taddr), .switch_en_o(sw), .ref_mv_o(ref_mv),
    .feedback_source_select_o(fbsel), .fb_ratio_o(ratio),
    .forced_fixed_rate_mode_o(fixed), .bleed_o(bleed),
    .uvlo_discharge_o(udis), .freq_khz_o(freq));
  bbes_ctrl_model u_ctrl (.clk_i(clk), .rd_data_i(rdata), .addr_o(addr),
    .wr_data_o(wdata), .wr_o(wr), .rd_o(rd));

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // Compares one value and reports a difference at once.
  task automatic check(input string n, input logic [11:0] s,
                       input logic [11:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : check

  // Lets n edges pass and settles past the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  function automatic logic pick(input int s);
    case (s)
      0: return bus;
      1: return sw;
      2: return bleed;
      default: return udis;
    endcase
  endfunction : pick

  // Bounded wait for a status output; running out ends the run.
  task automatic wait_bit(input int s, input logic v, input string n);
    int k;
    k = 0;
    while (pick(s) !== v && k < 2 * SS) begin
      cyc(1);
      k++;
    end
    check(n, pick(s), v);
    if (k >= 2 * SS) summarize();
  endtask : wait_bit

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_ctrl.read_reg(a, d);
    check("rd_data", d, e);
  endtask : rd_chk

  // Standby with a strap code, a write that must be ignored, then enable.
  task automatic power_up(input logic [2:0] code);
    en_off <= 1'b0;
    vin3   <= 1'b1;
    en_hi  <= 1'b1;
    {dt1, dt2, dt3} <= code;
    cyc(30);
    u_ctrl.write_reg(8'h04, 8'h03);
    en_uv  <= 1'b1;
    wait_bit(0, 1'b1, "bus_active");
    {dt1, dt2, dt3} <= 3'b000;
  endtask : power_up

  // Pin pulled below the shutdown level; registers, strap result and state return to defaults.
  task automatic power_down;
    en_off <= 1'b1;
    en_hi  <= 1'b0;
    en_uv  <= 1'b0;
    vin3   <= 1'b0;
    cyc(6);
    check("target_addr", taddr, 12'h075);
    check("bus_active", bus, 1'b0);
    en_off <= 1'b0;
  endtask : power_down

  task automatic t_ldo;
    vgt <= 1'b1;
    l62 <= 1'b1;
    cyc(4);
    check("ldo", ldo, 1'b1);
    l62 <= 1'b0;
    cyc(4);
    check("ldo", ldo, 1'b1);
    l59 <= 1'b1;
    cyc(4);
    check("ldo", ldo, 1'b0);
    {vgt, l59, l62} <= 3'b001;
    cyc(4);
    check("ldo", ldo, 1'b0);
    l62 <= 1'b0;
  endtask : t_ldo

  // Every strap code: address, default enable, and the held result.
  task automatic t_strap;
    logic [2:0] c;
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 3'b000 : (i == 1) ? 3'b001 : (i == 2) ? 3'b011 : 3'b111;
      power_up(c);
      check("target_addr", taddr, c[1] ? 12'h074 : 12'h075);
      cyc(12);
      check("switch_en", sw, c[0] ^ c[1] ^ c[2]);
      check("fb_select", fbsel, c[0] ^ c[1] ^ c[2]);
      rd_chk(8'h04, {c[0] ^ c[1] ^ c[2], 7'h00});
      check("target_addr", taddr, c[1] ? 12'h074 : 12'h075);
      power_down();
    end
  endtask : t_strap

  task automatic t_soft;
    power_up(3'b000);
    u_ctrl.write_reg(8'h04, 8'h03);
    cyc(2);
    check("fb_ratio", ratio, 2'h3);
    u_ctrl.write_reg(8'h06, 8'h04);  // Rate first, then enable.
    u_ctrl.write_reg(8'h06, 8'h84);
    wait_bit(1, 1'b1, "switch_en");
    check("ref_start", ref_mv < 11'h014, 1'b1);
    cyc(SS / 2);
    check("ref_mid", ref_mv > 11'h06E && ref_mv < 11'h0AA, 1'b1);
    cyc(SS);
    check("ref_mv", ref_mv, 12'h11A);
    check("freq_khz", freq, RATES[1]);
    rd_chk(8'h07, 8'h37);
    u_ctrl.write_reg(8'h06, 8'h44);
    wait_bit(1, 1'b0, "switch_en");
    wait_bit(2, 1'b1, "bleed");
    rd_chk(8'h06, 8'h44);
    vo08 <= 1'b1;
    wait_bit(2, 1'b0, "bleed");
    vo08 <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      u_ctrl.write_reg(8'h06, {4'h0, r[1:0], 2'b00});
      cyc(4);
      check("freq_khz", freq, RATES[r]);
    end
    power_down();
  endtask : t_soft

  // Triangle span and half period at the lowest rate.
  task automatic t_dither;
    logic [11:0] mn, mx;
    int          tmn, tmx;
    mn = 12'hFFF;
    mx = 12'h000;
    power_up(3'b001);
    wait_bit(1, 1'b1, "switch_en");
    u_ctrl.write_reg(8'h06, 8'h92);
    cyc(2);
    check("fixed_rate", fixed, 1'b1);
    for (int i = 0; i < 14000; i++) begin
      cyc(1);
      if (freq < mn) {mn, tmn} = {freq, i};
      if (freq > mx) {mx, tmx} = {freq, i};
    end
    check("freq_min", mn, 12'h174);
    check("freq_max", mx, 12'h1AC);
    tmx = (tmx > tmn) ? tmx - tmn : tmn - tmx;
    check("half_period", tmx > 6500 && tmx < 6800, 1'b1);
    u_ctrl.write_reg(8'h06, 8'h80);
    cyc(4);
    check("fixed_rate", fixed, 1'b0);
    check("freq_khz", freq, RATES[0]);
    power_down();
  endtask : t_dither

  task automatic t_lockout;
    power_up(3'b000);
    u_ctrl.write_reg(8'h06, 8'h80);
    wait_bit(1, 1'b1, "switch_en");
    vin24 <= 1'b1;
    wait_bit(3, 1'b1, "uvlo_discharge");
    wait_bit(1, 1'b0, "switch_en");
    rd_chk(8'h06, 8'h80);
    vcc_uv <= 1'b1;
    wait_bit(3, 1'b0, "uvlo_discharge");
    power_down();
    {vcc_uv, vin24} <= 2'b00;
    rd_chk(8'h06, 8'h00);
  endtask : t_lockout

  // Reset, then every scenario in turn.
  initial begin
    {resetn, vin3, vin24, en_hi, en_uv, en_off, vgt, l62, l59} = '0;
    {dt1, dt2, dt3, vo08, vcc_uv, fail_count, compares} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cyc(1);
    check("target_addr", taddr, 12'h075);
    check("freq_khz", freq, RATES[0]);
    check("switch_en", sw, 1'b0);
    t_ldo();
    t_strap();
    t_soft();
    t_dither();
    t_lockout();
    summarize();
  end
endmodule : tb
